// *** rtl/mcg_consts.vh ***
// constants for the microcontroller address map and interrupt glue
// assumes inclusion by rtl files only; definitions only
`ifndef MCG_CONSTS_VH
`define MCG_CONSTS_VH

// i/o register offsets (byte addresses = offset * 4 on the bus)
`define MCG_IDX_PA_DATA     8'h00
`define MCG_IDX_PB_DATA     8'h01
`define MCG_IDX_PC_DATA     8'h02
`define MCG_IDX_PA_DIR      8'h04
`define MCG_IDX_PB_DIR      8'h05
`define MCG_IDX_PC_DIR      8'h06
`define MCG_IDX_TICK_CS     8'h08
`define MCG_IDX_TICK_CNT    8'h09
`define MCG_IDX_CAR_PH      8'h10
`define MCG_IDX_CAR_PL      8'h11
`define MCG_IDX_CAR_SH      8'h12
`define MCG_IDX_CAR_SL      8'h13
`define MCG_IDX_MOD_CS      8'h14
`define MCG_IDX_MOD_PU      8'h15
`define MCG_IDX_MOD_ML      8'h16
`define MCG_IDX_MOD_SL      8'h17
// own registers: factory options, cpu-side status
`define MCG_IDX_OPTIONS     8'h20
`define MCG_IDX_PULLUP      8'h21
`define MCG_IDX_STATUS      8'h22

// address map
`define MCG_IO_LAST         14'h001f
`define MCG_RAM_FIRST       14'h0020
`define MCG_RAM_LAST        14'h017f
`define MCG_ROM_FIRST       14'h0180
`define MCG_ROM_LAST        14'h3faf
`define MCG_BURN_FIRST      14'h3fb0
`define MCG_BURN_LAST       14'h3fef
`define MCG_VEC_FIRST       14'h3ff0
`define MCG_VEC_SYS_FIRST   14'h3ff6

// region codes
`define MCG_REG_NONE        3'h0
`define MCG_REG_IO          3'h1
`define MCG_REG_RAM         3'h2
`define MCG_REG_ROM         3'h3
`define MCG_REG_BURN        3'h4
`define MCG_REG_VEC         3'h5

// field positions and write masks
`define MCG_OPT_STOP        0
`define MCG_OPT_LEVEL       1
`define MCG_OPT_SECURE      2
`define MCG_CS_CLEAR_OVF    3
`define MCG_CS_CLEAR_PER    2
`define MCG_CS_WR_MASK      8'h33
`define MCG_CARRIER_PRIMARY_HIGH_MASK       8'hbf
`define MCG_CARRIER_SECONDARY_HIGH_MASK       8'h3f
`define MCG_MODULATOR_CTRL_STATUS_MASK       8'h3f

// misc
`define MCG_AXI_OKAY        2'h0
`define MCG_AXI_SLVERR      2'h2
`define MCG_ZERO8           8'h00

`endif

// *** rtl/mcg_addr_decode.v ***
// region decoder for the 16 kbyte cpu address space
// assumes a 14-bit cpu address from the same clock domain
`timescale 1ns/1ps
`include "mcg_consts.vh"
module mcg_addr_decode (
  // cpu address
  input  wire [13:0] addr,
  // decoded region and system vector flag
  output reg  [2:0]  region,
  output wire        sys_vector
);
  always @* begin
    if (addr <= `MCG_IO_LAST) begin
      region = `MCG_REG_IO;
    end else if (addr <= `MCG_RAM_LAST) begin
      region = `MCG_REG_RAM;
    end else if (addr <= `MCG_ROM_LAST) begin
      region = `MCG_REG_ROM;
    end else if (addr <= `MCG_BURN_LAST) begin
      region = `MCG_REG_BURN;
    end else begin
      region = `MCG_REG_VEC;
    end
  end
  // ten top bytes hold reset and interrupt vectors
  assign sys_vector = (addr >= `MCG_VEC_SYS_FIRST);
endmodule

// *** rtl/mcg_top.v ***
// What this block does
// - stop option clear makes stop behave as wait; set keeps stop.
// - sensitivity option 1 gives edge and level, 0 falling edge only.
// - keyscan inputs use the same sensitivity as the request pin.
// - request pin edge detect sees falling edges; level sees held low.
// - a low request pulse sets the internal request latch to 1.
// - latch tested after instruction end; taken if set and unmasked.
// - bus clock runs at half the oscillator rate.
// - reset pin low resets core, ports, registers, interrupt and modes; axi port and bus clock are not reset.
// - low-power reset holds device in reset, processor clocks stopped.
// - after any reset all port direction bits are cleared.
// - each port b line has its own pullup and keyscan enable.
// - port c is a full eight-bit port with data and direction.
// - decoder maps 16 kbyte of i/o, ram, user rom, burn-in rom.
// - port data at 0x00-0x02, direction at 0x04-0x06, 0x03/0x07 free.
// - timer control at 0x08 with flags bits 7,6; counter at 0x09.
// - user rom 0x0180-0x3faf, sixteen vector bytes 0x3ff0-0x3fff.
// - burn-in rom decodes 0x3fb0 to 0x3fef.
// - bytes 0x3ff6-0x3fff are vectors; 0x3ff0-0x3ff5 decode as vector region with sys_vector clear.
// - rom contents cannot be read out externally when secured.
// - user ram decodes 0x0020 to 0x017f.
// - a masked request stays latched, served once mask clears.
//
// holds the axi4-lite register slave, interrupt latch, reset and clocks
// assumes pins are asynchronous; cpu core signals share aclk
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "mcg_consts.vh"
module mcg_top (
  // clock and bus reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // device pins
  input  wire        reset_n_pin,
  input  wire        low_power_reset_pin_n,
  input  wire        irq_n_pin,
  input  wire [7:0]  port_b_pin,
  // factory options
  input  wire        stop_instr_option,
  input  wire        irq_level_option,
  input  wire [7:0]  keyscan_pullup_option,
  input  wire        rom_secure_option,
  // cpu core side
  input  wire [13:0] cpu_addr,
  input  wire        cpu_stop_instr,
  input  wire        cpu_wait_instr,
  input  wire        cpu_instr_done,
  input  wire        cpu_int_mask,
  input  wire        cpu_int_ack,
  input  wire        cpu_external_fetch,
  output wire [2:0]  cpu_region,
  output wire        cpu_sys_vector,
  output wire        cpu_read_block,
  output reg         cpu_int_start,
  output reg         stop_mode,
  output reg         wait_mode,
  output reg         bus_clk,
  output reg         proc_clk_en,
  output reg         core_reset,
  // timer hookups
  input  wire [7:0]  tick_timer_count,
  input  wire        tick_overflow_flag,
  input  wire        periodic_int_flag,
  output wire        tick_overflow_clear,
  output wire        periodic_flag_clear,
  // port outputs
  output reg  [7:0]  port_a_data,
  output reg  [7:0]  port_b_data,
  output reg  [7:0]  port_c_data,
  output reg  [7:0]  port_a_direction,
  output reg  [7:0]  port_b_direction,
  output reg  [7:0]  port_c_direction,
  output wire [7:0]  port_b_pullup_en
);
  // synchronisers: first stage read only by the second
  reg [10:0] sync1;
  reg [10:0] sync2;
  always @(posedge aclk) begin
    sync1 <= {reset_n_pin, low_power_reset_pin_n, irq_n_pin, port_b_pin};
    sync2 <= sync1;
  end
  wire       rst_pin_n = sync2[10];
  wire       lp_pin_n  = sync2[9];
  wire       irq_n     = sync2[8];
  wire [7:0] kb_pins   = sync2[7:0];

  // device reset: bus reset, reset pin or low-power reset
  wire dev_rst = !aresetn || !rst_pin_n || !lp_pin_n;
  always @(posedge aclk) begin
    core_reset  <= dev_rst;
    proc_clk_en <= aresetn && lp_pin_n;
  end

  // bus clock toggles each rising aclk edge: half the oscillator rate
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_clk <= 1'b0;
    end else if (!lp_pin_n) begin
      bus_clk <= 1'b0;
    end else begin
      bus_clk <= !bus_clk;
    end
  end

  // keyscan lines enabled per bit by option, shared with request pin
  wire [7:0] kb_low = ~kb_pins & keyscan_pullup_option;
  wire       ext_low = !irq_n || (|kb_low);
  reg        ext_low_q;
  reg        irq_latch;
  wire       fall = ext_low && !ext_low_q;
  wire       lvl  = irq_level_option && ext_low;
  assign port_b_pullup_en = keyscan_pullup_option;

  always @(posedge aclk) begin
    if (dev_rst) begin
      ext_low_q     <= 1'b0;
      irq_latch     <= 1'b0;
      cpu_int_start <= 1'b0;
    end else begin
      ext_low_q     <= ext_low;
      cpu_int_start <= 1'b0;
      // set wins over the acknowledge clear; masked request is held
      if (fall || lvl) begin
        irq_latch <= 1'b1;
      end else if (cpu_int_ack) begin
        irq_latch <= 1'b0;
      end
      if (cpu_instr_done && irq_latch && !cpu_int_mask) begin
        cpu_int_start <= 1'b1;
      end
    end
  end

  // stop and wait low-power modes, left on any interrupt
  always @(posedge aclk) begin
    if (dev_rst) begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else if (irq_latch) begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else if (cpu_stop_instr && stop_instr_option) begin
      stop_mode <= 1'b1;
    end else if (cpu_wait_instr || cpu_stop_instr) begin
      wait_mode <= 1'b1;
    end
  end

  // address decoder
  mcg_addr_decode u_dec (
    .addr       (cpu_addr),
    .region     (cpu_region),
    .sys_vector (cpu_sys_vector)
  );
  // rom fetch by an outside agent is blocked when secured
  assign cpu_read_block = rom_secure_option && cpu_external_fetch &&
    (cpu_region >= `MCG_REG_ROM);

  // axi4-lite write path: take address and data in either order
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire       aw_take = s_axi_awvalid && s_axi_awready;
  wire       w_take  = s_axi_wvalid && s_axi_wready;
  wire       wa_ok   = aw_held || aw_take;
  wire       wd_ok   = w_held || w_take;
  wire [7:0] wa      = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd     = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws      = w_held ? w_strb : s_axi_wstrb;
  wire       do_wr   = wa_ok && wd_ok && !s_axi_bvalid;
  wire [5:0] widx    = wa[7:2];
  wire       wlane   = ws[0];
  wire [7:0] wbyte   = wd[7:0];

  // own registers
  reg [7:0] tick_cs;
  reg [7:0] car_ph;
  reg [7:0] car_pl;
  reg [7:0] car_sh;
  reg [7:0] car_sl;
  reg [7:0] mod_cs;
  reg [7:0] mod_pu;
  reg [7:0] mod_ml;
  reg [7:0] mod_sl;
  reg       wr_mapped;
  reg       clr_ovf;
  reg       clr_per;

  always @* begin
    case ({2'b00, widx})
      `MCG_IDX_PA_DATA, `MCG_IDX_PB_DATA, `MCG_IDX_PC_DATA,
      `MCG_IDX_PA_DIR, `MCG_IDX_PB_DIR, `MCG_IDX_PC_DIR,
      `MCG_IDX_TICK_CS, `MCG_IDX_TICK_CNT, `MCG_IDX_CAR_PH,
      `MCG_IDX_CAR_PL, `MCG_IDX_CAR_SH, `MCG_IDX_CAR_SL,
      `MCG_IDX_MOD_CS, `MCG_IDX_MOD_PU, `MCG_IDX_MOD_ML,
      `MCG_IDX_MOD_SL, `MCG_IDX_OPTIONS, `MCG_IDX_PULLUP,
      `MCG_IDX_STATUS: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // timer flag clears are one-cycle pulses, never stored
  wire cs_wr = do_wr && wlane && ({2'b00, widx} == `MCG_IDX_TICK_CS);
  always @* begin
    clr_ovf = cs_wr && wbyte[`MCG_CS_CLEAR_OVF];
    clr_per = cs_wr && wbyte[`MCG_CS_CLEAR_PER];
  end
  assign tick_overflow_clear = clr_ovf;
  assign periodic_flag_clear = clr_per;

  always @(posedge aclk) begin
    if (dev_rst) begin
      port_a_direction <= `MCG_ZERO8;
      port_b_direction <= `MCG_ZERO8;
      port_c_direction <= `MCG_ZERO8;
      port_a_data      <= `MCG_ZERO8;
      port_b_data      <= `MCG_ZERO8;
      port_c_data      <= `MCG_ZERO8;
      tick_cs          <= `MCG_ZERO8;
      car_ph           <= `MCG_ZERO8;
      car_pl           <= `MCG_ZERO8;
      car_sh           <= `MCG_ZERO8;
      car_sl           <= `MCG_ZERO8;
      mod_cs           <= `MCG_ZERO8;
      mod_pu           <= `MCG_ZERO8;
      mod_ml           <= `MCG_ZERO8;
      mod_sl           <= `MCG_ZERO8;
    end else if (do_wr && wlane) begin
      case ({2'b00, widx})
        `MCG_IDX_PA_DATA: port_a_data <= wbyte;
        `MCG_IDX_PB_DATA: port_b_data <= wbyte;
        `MCG_IDX_PC_DATA: port_c_data <= wbyte;
        `MCG_IDX_PA_DIR:  port_a_direction <= wbyte;
        `MCG_IDX_PB_DIR:  port_b_direction <= wbyte;
        `MCG_IDX_PC_DIR:  port_c_direction <= wbyte;
        `MCG_IDX_TICK_CS: tick_cs <= wbyte & `MCG_CS_WR_MASK;
        `MCG_IDX_CAR_PH:  car_ph <= wbyte & `MCG_CARRIER_PRIMARY_HIGH_MASK;
        `MCG_IDX_CAR_PL:  car_pl <= wbyte & `MCG_CARRIER_PRIMARY_HIGH_MASK;
        `MCG_IDX_CAR_SH:  car_sh <= wbyte & `MCG_CARRIER_SECONDARY_HIGH_MASK;
        `MCG_IDX_CAR_SL:  car_sl <= wbyte & `MCG_CARRIER_SECONDARY_HIGH_MASK;
        `MCG_IDX_MOD_CS:  mod_cs <= wbyte & `MCG_MODULATOR_CTRL_STATUS_MASK;
        `MCG_IDX_MOD_PU:  mod_pu <= wbyte;
        `MCG_IDX_MOD_ML:  mod_ml <= wbyte;
        `MCG_IDX_MOD_SL:  mod_sl <= wbyte;
        default: ;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= `MCG_ZERO8;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCG_AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `MCG_AXI_OKAY : `MCG_AXI_SLVERR;
      end else begin
        aw_held <= aw_held || aw_take;
        w_held  <= w_held || w_take;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read path: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] ridx = {2'b00, s_axi_araddr[7:2]};
  reg  [7:0] rbyte;
  reg        rmapped;
  always @* begin
    rmapped = 1'b1;
    case (ridx)
      `MCG_IDX_PA_DATA:  rbyte = port_a_data;
      `MCG_IDX_PB_DATA:  rbyte = port_b_data;
      `MCG_IDX_PC_DATA:  rbyte = port_c_data;
      `MCG_IDX_PA_DIR:   rbyte = port_a_direction;
      `MCG_IDX_PB_DIR:   rbyte = port_b_direction;
      `MCG_IDX_PC_DIR:   rbyte = port_c_direction;
      // flags live in the timer; clear bits always read zero
      `MCG_IDX_TICK_CS:  rbyte = {tick_overflow_flag, periodic_int_flag,
                                  6'h00} |
                                 tick_cs;
      `MCG_IDX_TICK_CNT: rbyte = tick_timer_count;
      `MCG_IDX_CAR_PH:   rbyte = car_ph;
      `MCG_IDX_CAR_PL:   rbyte = car_pl;
      `MCG_IDX_CAR_SH:   rbyte = car_sh;
      `MCG_IDX_CAR_SL:   rbyte = car_sl;
      `MCG_IDX_MOD_CS:   rbyte = mod_cs;
      `MCG_IDX_MOD_PU:   rbyte = mod_pu;
      `MCG_IDX_MOD_ML:   rbyte = mod_ml;
      `MCG_IDX_MOD_SL:   rbyte = mod_sl;
      `MCG_IDX_OPTIONS:  rbyte = {5'h00, rom_secure_option,
                                  irq_level_option, stop_instr_option};
      `MCG_IDX_PULLUP:   rbyte = keyscan_pullup_option;
      `MCG_IDX_STATUS:   rbyte = {4'h0, irq_latch, ext_low,
                                  wait_mode, stop_mode};
      default: begin
        rbyte   = `MCG_ZERO8;
        rmapped = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MCG_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rbyte};
      s_axi_rresp  <= rmapped ? `MCG_AXI_OKAY : `MCG_AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** bench/mcg_top_monitor.sv ***
// checker for reset, interrupt and address decode of mcg_top
// assumes it is bound into mcg_top and sees only its ports
`timescale 1ns/1ps
module mcg_top_monitor (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // pins and options
  input logic        reset_n_pin,
  input logic        low_power_reset_pin_n,
  input logic        stop_instr_option,
  input logic        rom_secure_option,
  // cpu side
  input logic [13:0] cpu_addr,
  input logic        cpu_stop_instr,
  input logic        cpu_instr_done,
  input logic        cpu_int_mask,
  input logic        cpu_external_fetch,
  input logic [2:0]  cpu_region,
  input logic        cpu_sys_vector,
  input logic        cpu_read_block,
  input logic        cpu_int_start,
  input logic        stop_mode,
  input logic        wait_mode,
  input logic        bus_clk,
  input logic        proc_clk_en,
  input logic        core_reset,
  // port directions
  input logic [7:0]  port_a_direction,
  input logic [7:0]  port_b_direction,
  input logic [7:0]  port_c_direction
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic logic [2:0] mcg_want(input logic [13:0] a);
    if (a <= 14'h001f) return 3'h1;
    if (a <= 14'h017f) return 3'h2;
    if (a <= 14'h3faf) return 3'h3;
    if (a <= 14'h3fef) return 3'h4;
    return 3'h5;
  endfunction
  wire [23:0] dirs = {port_a_direction, port_b_direction, port_c_direction};
  a_dir_clear: assert property ($rose(aresetn) |-> dirs == 24'h0)
    else $error("directions not cleared by reset");
  a_stop_as_wait: assert property (
    cpu_stop_instr && !stop_instr_option |=> wait_mode && !stop_mode)
    else $error("stop not turned into wait");
  a_stop_kept: assert property (
    cpu_stop_instr && stop_instr_option |=> stop_mode)
    else $error("stop mode not entered");
  a_start_cause: assert property (
    cpu_int_start |-> $past(cpu_instr_done) && !$past(cpu_int_mask))
    else $error("interrupt start without unmasked instruction end");
  a_mask_holds: assert property (
    cpu_instr_done && cpu_int_mask |=> !cpu_int_start)
    else $error("interrupt started while masked");
  // clocks may freeze in low-power reset, so only judge while running
  a_bus_half: assert property (
    (proc_clk_en && !core_reset) [*3] |-> bus_clk != $past(bus_clk))
    else $error("bus clock not at half rate");
  a_lpr_halt: assert property (
    !low_power_reset_pin_n [*4] |-> core_reset && !proc_clk_en)
    else $error("low-power reset did not halt");
  a_pin_reset: assert property (
    !reset_n_pin [*4] |-> core_reset && dirs == 24'h0)
    else $error("reset pin did not reset");
  a_region_map: assert property (
    cpu_region == mcg_want(cpu_addr))
    else $error("region decode wrong");
  a_vector_flag: assert property (
    cpu_sys_vector == (cpu_addr >= 14'h3ff6))
    else $error("vector flag wrong");
  a_rom_guard: assert property (
    cpu_read_block == (rom_secure_option && cpu_external_fetch &&
                       mcg_want(cpu_addr) >= 3'h3))
    else $error("rom read guard wrong");
endmodule
bind mcg_top mcg_top_monitor u_mcg_top_monitor (
  .aclk, .aresetn, .reset_n_pin, .low_power_reset_pin_n,
  .stop_instr_option, .rom_secure_option, .cpu_addr, .cpu_stop_instr,
  .cpu_instr_done, .cpu_int_mask, .cpu_external_fetch, .cpu_region,
  .cpu_sys_vector, .cpu_read_block, .cpu_int_start, .stop_mode,
  .wait_mode, .bus_clk, .proc_clk_en, .core_reset, .port_a_direction,
  .port_b_direction, .port_c_direction
);

// *** bench/mcg_core_model.sv ***
// behavioural cpu core: ends an instruction every few cycles
// assumes the block's aclk and aresetn; acks each start
`timescale 1ns/1ps
module mcg_core_model #(
  parameter int GAP = 4
) (
  // clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // core handshake
  input  logic       cpu_int_start,
  output logic       cpu_instr_done,
  output logic       cpu_int_ack,
  output logic [7:0] starts
);
  logic [3:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 4'h0;
      cpu_instr_done <= 1'b0;
      cpu_int_ack <= 1'b0;
      starts <= 8'h00;
    end else begin
      cnt <= (cnt == 4'(GAP - 1)) ? 4'h0 : cnt + 4'h1;
      // requests are only looked at here, never mid-instruction
      cpu_instr_done <= (cnt == 4'(GAP - 1));
      cpu_int_ack <= cpu_int_start;
      starts <= starts + {7'h0, cpu_int_start};
    end
  end
endmodule

// *** bench/tb.sv ***
// self-checking bench: registers, resets, interrupts, decode
// assumes mcg_top, the core model and the bound checker
`timescale 1ns/1ps
module tb;
  // clock and bus
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  // ready lines stay high: answers are never held off by the bench
  logic        s_axi_bready = 1'b1, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  // pins, options, core side
  logic        reset_n_pin = 1'b1, low_power_reset_pin_n = 1'b1;
  logic        irq_n_pin = 1'b1, stop_instr_option = 1'b0;
  logic        irq_level_option = 1'b0, rom_secure_option = 1'b0;
  logic        cpu_stop_instr = 1'b0, cpu_wait_instr = 1'b0;
  logic        cpu_int_mask = 1'b1, cpu_external_fetch = 1'b0;
  logic        tick_overflow_flag = 1'b0, periodic_int_flag = 1'b0;
  logic [7:0]  port_b_pin = 8'hff, keyscan_pullup_option = 8'h00;
  logic [7:0]  tick_timer_count = 8'h00;
  logic [13:0] cpu_addr = 14'h0;
  wire         cpu_instr_done, cpu_int_ack, cpu_int_start;
  wire         stop_mode, wait_mode, proc_clk_en;
  wire         tick_overflow_clear, periodic_flag_clear;
  wire  [7:0]  port_c_direction, starts, port_b_pullup_en;
  // bench state
  logic [15:0] seed = 16'h0005;
  logic [31:0] rq;
  logic [1:0]  rrq, bq;
  logic        clr_seen = 1'b0;
  int          n_mismatch = 0, compares = 0;
  logic [7:0]  pidx [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06};
  logic [7:0]  ridx [3] = '{8'h03, 8'h07, 8'h0a};
  logic [7:0]  midx [3] = '{8'h10, 8'h12, 8'h14};
  logic [7:0]  mval [3] = '{8'hbf, 8'h3f, 8'h3f};
  logic [13:0] bnd [11] = '{14'h1f, 14'h20, 14'h17f, 14'h180, 14'h3faf,
    14'h3fb0, 14'h3fef, 14'h3ff0, 14'h3ff5, 14'h3ff6, 14'h3fff};
  mcg_top u_mcg_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_n_pin, .low_power_reset_pin_n, .irq_n_pin,
    .port_b_pin, .stop_instr_option, .irq_level_option,
    .keyscan_pullup_option, .rom_secure_option, .cpu_addr, .cpu_stop_instr,
    .cpu_wait_instr, .cpu_instr_done, .cpu_int_mask, .cpu_int_ack,
    .cpu_external_fetch, .cpu_region(), .cpu_sys_vector(),
    .cpu_read_block(), .cpu_int_start, .stop_mode, .wait_mode,
    .bus_clk(), .proc_clk_en, .core_reset(), .tick_timer_count,
    .tick_overflow_flag, .periodic_int_flag, .tick_overflow_clear,
    .periodic_flag_clear, .port_a_data(), .port_b_data(), .port_c_data(),
    .port_a_direction(), .port_b_direction(), .port_c_direction,
    .port_b_pullup_en
  );
  mcg_core_model u_mcg_core_model (
    .aclk, .aresetn, .cpu_int_start, .cpu_instr_done, .cpu_int_ack, .starts
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    s_axi_awaddr <= {i[5:0], 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bq = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] i);
    s_axi_araddr <= {i[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rq = s_axi_rdata;
    rrq = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e,
                      input logic [1:0] er);
    rd(i);
    chk("rdata", e, rq);
    chk("rresp", {30'h0, er}, {30'h0, rrq});
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // the run needs under 2000 cycles; 20000 means a hang
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
  always @(posedge aclk) begin
    if (tick_overflow_clear && periodic_flag_clear) clr_seen <= 1'b1;
  end
  initial begin
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    for (int i = 4; i < 7; i++) rchk(8'(i), 32'h0, 2'h0);
    foreach (pidx[i]) begin
      seed = lfsr(seed);
      wr(pidx[i], seed[7:0]);
      chk("bresp", 32'h0, {30'h0, bq});
      rchk(pidx[i], {24'h0, seed[7:0]}, 2'h0);
    end
    wr(8'h06, 8'hf0);
    chk("port_c_direction", 32'hf0, {24'h0, port_c_direction});
    foreach (ridx[i]) begin
      wr(ridx[i], 8'hff);
      rd(ridx[i]);
      chk("reserved", 32'h0, rq);
    end
    rchk(8'h30, 32'h0, 2'h2);
    tick_overflow_flag <= 1'b1;
    wr(8'h08, 8'hff);
    rchk(8'h08, 32'hb3, 2'h0);
    chk("flag clear", 32'h1, {31'h0, clr_seen});
    seed = lfsr(seed);
    tick_timer_count <= seed[7:0];
    rchk(8'h09, {24'h0, seed[7:0]}, 2'h0);
    foreach (midx[i]) begin
      wr(midx[i], 8'hff);
      rchk(midx[i], {24'h0, mval[i]}, 2'h0);
    end
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      cpu_addr <= (i < 11) ? bnd[i] : seed[13:0];
      rom_secure_option <= seed[14];
      cpu_external_fetch <= seed[15];
      tick(1);
    end
    irq_n_pin <= 1'b0;
    tick(12);
    chk("masked", 32'h0, {24'h0, starts});
    cpu_int_mask <= 1'b0;
    tick(12);
    chk("unmasked", 32'h1, {24'h0, starts});
    tick(12);
    chk("edge only", 32'h1, {24'h0, starts});
    irq_n_pin <= 1'b1;
    keyscan_pullup_option <= 8'h08;
    tick(4);
    chk("pullup_en", 32'h08, {24'h0, port_b_pullup_en});
    port_b_pin <= 8'hf7;
    tick(12);
    chk("keyscan", 32'h2, {24'h0, starts});
    port_b_pin <= 8'hff;
    keyscan_pullup_option <= 8'hf7;
    tick(4);
    port_b_pin <= 8'hf7;
    tick(12);
    chk("line disabled", 32'h2, {24'h0, starts});
    port_b_pin <= 8'hff;
    irq_level_option <= 1'b1;
    tick(4);
    irq_n_pin <= 1'b0;
    tick(30);
    chk("level", 32'h1, {31'h0, starts > 8'h04});
    irq_n_pin <= 1'b1;
    irq_level_option <= 1'b0;
    tick(12);
    for (int i = 0; i < 2; i++) begin
      stop_instr_option <= i[0];
      tick(1);
      cpu_stop_instr <= 1'b1;
      tick(1);
      cpu_stop_instr <= 1'b0;
      tick(1);
      chk("wait_mode", {31'h0, ~i[0]}, {31'h0, wait_mode});
      chk("stop_mode", {31'h0, i[0]}, {31'h0, stop_mode});
      irq_n_pin <= 1'b0;
      tick(4);
      irq_n_pin <= 1'b1;
      tick(12);
    end
    cpu_wait_instr <= 1'b1;
    tick(1);
    cpu_wait_instr <= 1'b0;
    tick(1);
    chk("wait instr", 32'h1, {31'h0, wait_mode});
    wr(8'h04, 8'h5a);
    reset_n_pin <= 1'b0;
    tick(5);
    reset_n_pin <= 1'b1;
    tick(4);
    rchk(8'h04, 32'h0, 2'h0);
    low_power_reset_pin_n <= 1'b0;
    tick(6);
    chk("proc_clk_en", 32'h0, {31'h0, proc_clk_en});
    low_power_reset_pin_n <= 1'b1;
    tick(6);
    chk("proc_clk_en", 32'h1, {31'h0, proc_clk_en});
    report_and_stop();
  end
endmodule
